// ---- crf_fifo.sv ----
// shared constants and the result fifo of the conversion ready flag block
`timescale 1ns/1ns
`default_nettype none

package crf_pkg;
    localparam int CMD_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 17;
    // communications byte fields
    localparam int COMM_RW_POS = 6;
    localparam int COMM_SEL_LSB = 0;
    localparam int COMM_SEL_W = 4;
    // register selection codes
    localparam logic [3:0] SEL_STATUS = 4'h0;
    localparam logic [3:0] SEL_MODE = 4'h1;
    localparam logic [3:0] SEL_CTRL = 4'h2;
    localparam logic [3:0] SEL_MAIN = 4'h3;
    localparam logic [3:0] SEL_AUX = 4'h4;
    localparam logic [3:0] SEL_CAL = 4'h5;
    // status register bit positions
    localparam int ST_MAIN_POS = 0;
    localparam int ST_AUX_POS = 1;
    localparam int ST_HOLD_POS = 2;
    // reset values
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CAL_RST = 16'h8000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // serial states, gray along idle -> command -> data
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_DATA = 2'b11
    } crf_state_e;
endpackage

module crf_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic rdy_r, rdy_nxt;
    logic push, pop;

    assign push = in_valid && rdy_r;
    assign pop = out_valid && out_ready;
    assign in_ready = rdy_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        rdy_nxt = (cnt_nxt != DEPTH[AW:0]);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

`default_nettype wire

// ---- crf_ready.sv ----
// conversion ready flag, serial register port and result registers
`timescale 1ns/1ns
`default_nettype none

module crf_ready (
    input wire logic clk,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic sclk_pin,
    input wire logic cs_pin_n,
    input wire logic din_pin,
    output logic dout,
    output logic ready_n,
    input wire logic main_enable,
    input wire logic aux_enable,
    input wire logic result_valid,
    input wire logic result_is_aux,
    input wire logic [15:0] result_data,
    output logic result_ready,
    input wire logic cal_done,
    output logic mode_start,
    output logic [15:0] mode_word,
    output logic [15:0] ctrl_word,
    output logic [15:0] cal_word
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s_rst_r, s_sclk_r, s_cs_r, s_din_r;
    logic rstn_f_r, rstn_f_nxt, sclk_f_r, sclk_f_nxt, cs_f_r, cs_f_nxt;
    logic rst_all, rise, fall, cs_low;

    always_comb begin
        rstn_f_nxt = (s_rst_r[1] == s_rst_r[2]) ? s_rst_r[2] : rstn_f_r;
        sclk_f_nxt = (s_sclk_r[1] == s_sclk_r[2]) ? s_sclk_r[2] : sclk_f_r;
        cs_f_nxt = (s_cs_r[1] == s_cs_r[2]) ? s_cs_r[2] : cs_f_r;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_rst_r <= 3'h7;
            s_sclk_r <= 3'h0;
            s_cs_r <= 3'h7;
            s_din_r <= 3'h0;
            rstn_f_r <= 1'b1;
            sclk_f_r <= 1'b0;
            cs_f_r <= 1'b1;
        end else begin
            s_rst_r <= {s_rst_r[1:0], reset_pin_n};
            s_sclk_r <= {s_sclk_r[1:0], sclk_pin};
            s_cs_r <= {s_cs_r[1:0], cs_pin_n};
            s_din_r <= {s_din_r[1:0], din_pin};
            rstn_f_r <= rstn_f_nxt;
            sclk_f_r <= sclk_f_nxt;
            cs_f_r <= cs_f_nxt;
        end
    end

    assign rst_all = srst || !rstn_f_r;
    assign rise = sclk_f_nxt && !sclk_f_r;
    assign fall = !sclk_f_nxt && sclk_f_r;
    assign cs_low = !cs_f_r;

    // ------------------------------------------------------------
    // serial port and registers
    // ------------------------------------------------------------
    crf_pkg::crf_state_e st_r, st_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] isr_r, isr_nxt, osr_r, osr_nxt;
    logic rw_r, rw_nxt;
    logic [3:0] sel_r, sel_nxt;
    logic [15:0] mode_r, mode_nxt, ctrl_r, ctrl_nxt, cal_r, cal_nxt;
    logic [15:0] main_d_r, main_d_nxt, aux_d_r, aux_d_nxt;
    logic main_r, main_nxt, aux_r, aux_nxt, hold_r, hold_nxt;
    logic ready_n_r, ready_n_nxt, start_r, start_nxt;
    logic word_done, rd_done, wr_done, cmd_done;
    logic [15:0] status_w;
    logic drain_pop, drain_clear, lock;
    logic fifo_valid, fifo_aux;
    logic [15:0] fifo_data;
    logic [16:0] fifo_out;

    function automatic logic [15:0] reg_value(input logic [3:0] sel, input logic [15:0] st,
                                              input logic [15:0] md, input logic [15:0] ct,
                                              input logic [15:0] mn, input logic [15:0] ax,
                                              input logic [15:0] cl);
        case (sel)
            crf_pkg::SEL_STATUS: reg_value = st;
            crf_pkg::SEL_MODE: reg_value = md;
            crf_pkg::SEL_CTRL: reg_value = ct;
            crf_pkg::SEL_MAIN: reg_value = mn;
            crf_pkg::SEL_AUX: reg_value = ax;
            crf_pkg::SEL_CAL: reg_value = cl;
            default: reg_value = 16'h0000;
        endcase
    endfunction

    function automatic logic data_sel(input logic [3:0] sel, input logic is_aux);
        data_sel = is_aux ? (sel == crf_pkg::SEL_AUX) : (sel == crf_pkg::SEL_MAIN);
    endfunction

    always_comb begin
        status_w = 16'h0000;
        status_w[crf_pkg::ST_MAIN_POS] = main_r;
        status_w[crf_pkg::ST_AUX_POS] = aux_r;
        status_w[crf_pkg::ST_HOLD_POS] = hold_r;
    end

    assign fifo_aux = fifo_out[16];
    assign fifo_data = fifo_out[15:0];
    assign word_done = (st_r == crf_pkg::ST_DATA) && rise && (cnt_r == 5'(crf_pkg::WORD_BITS - 1));
    assign cmd_done = (st_r == crf_pkg::ST_CMD) && rise && (cnt_r == 5'(crf_pkg::CMD_BITS - 1));
    assign rd_done = word_done && rw_r;
    assign wr_done = word_done && !rw_r;
    // a read in flight from the targeted data register stalls the drain
    assign lock = (st_r == crf_pkg::ST_DATA) && rw_r && data_sel(sel_r, fifo_aux);
    assign drain_clear = fifo_valid && !lock && (fifo_aux ? aux_r : (main_r && !hold_r));
    assign drain_pop = fifo_valid && !lock && !drain_clear;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        isr_nxt = isr_r;
        osr_nxt = osr_r;
        rw_nxt = rw_r;
        sel_nxt = sel_r;
        mode_nxt = mode_r;
        ctrl_nxt = ctrl_r;
        cal_nxt = cal_r;
        start_nxt = 1'b0;
        case (st_r)
            crf_pkg::ST_IDLE: begin
                if (cs_low) begin
                    st_nxt = crf_pkg::ST_CMD;
                    cnt_nxt = 5'h00;
                end
            end
            crf_pkg::ST_CMD: begin
                if (rise) begin
                    isr_nxt = {isr_r[14:0], s_din_r[2]};
                    cnt_nxt = cnt_r + 5'h01;
                end
                if (cmd_done) begin
                    rw_nxt = isr_nxt[crf_pkg::COMM_RW_POS];
                    sel_nxt = isr_nxt[crf_pkg::COMM_SEL_LSB +: crf_pkg::COMM_SEL_W];
                    osr_nxt = reg_value(sel_nxt, status_w, mode_r, ctrl_r, main_d_r,
                                        aux_d_r, cal_r);
                    cnt_nxt = 5'h00;
                    st_nxt = crf_pkg::ST_DATA;
                end
            end
            crf_pkg::ST_DATA: begin
                if (rise) begin
                    isr_nxt = {isr_r[14:0], s_din_r[2]};
                    cnt_nxt = cnt_r + 5'h01;
                end
                if (fall && rw_r) begin
                    osr_nxt = {osr_r[14:0], 1'b0};
                end
                if (word_done) begin
                    cnt_nxt = 5'h00;
                    st_nxt = crf_pkg::ST_CMD;
                end
                if (wr_done) begin
                    case (sel_r)
                        crf_pkg::SEL_MODE: begin
                            mode_nxt = isr_nxt;
                            start_nxt = 1'b1;
                        end
                        crf_pkg::SEL_CTRL: ctrl_nxt = isr_nxt;
                        crf_pkg::SEL_CAL: cal_nxt = isr_nxt;
                        default: ;
                    endcase
                end
            end
            default: st_nxt = crf_pkg::ST_IDLE;
        endcase
        if (!cs_low) begin
            st_nxt = crf_pkg::ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // ready bits, set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        main_nxt = main_r;
        aux_nxt = aux_r;
        hold_nxt = hold_r;
        main_d_nxt = main_d_r;
        aux_d_nxt = aux_d_r;
        if (rd_done && sel_r == crf_pkg::SEL_MAIN && !hold_r) begin
            main_nxt = 1'b0;
        end
        if (rd_done && sel_r == crf_pkg::SEL_AUX) begin
            aux_nxt = 1'b0;
        end
        if (drain_clear) begin
            if (fifo_aux) begin
                aux_nxt = 1'b0;
            end else begin
                main_nxt = 1'b0;
            end
        end
        if (start_nxt) begin
            hold_nxt = 1'b0;
            main_nxt = 1'b0;
            aux_nxt = 1'b0;
        end
        if (drain_pop) begin
            if (fifo_aux) begin
                aux_d_nxt = fifo_data;
                aux_nxt = 1'b1;
            end else begin
                main_d_nxt = fifo_data;
                main_nxt = 1'b1;
            end
        end
        if (cal_done) begin
            hold_nxt = 1'b1;
            main_nxt = 1'b1;
        end
        main_nxt = main_nxt && main_enable;
        aux_nxt = aux_nxt && aux_enable;
        hold_nxt = hold_nxt && main_enable;
        ready_n_nxt = !(main_nxt || aux_nxt);
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            st_r <= crf_pkg::ST_IDLE;
            cnt_r <= 5'h00;
            isr_r <= 16'h0000;
            osr_r <= 16'h0000;
            rw_r <= 1'b0;
            sel_r <= crf_pkg::SEL_STATUS;
            mode_r <= crf_pkg::MODE_RST;
            ctrl_r <= crf_pkg::CTRL_RST;
            cal_r <= crf_pkg::CAL_RST;
            main_d_r <= crf_pkg::DATA_RST;
            aux_d_r <= crf_pkg::DATA_RST;
            main_r <= 1'b0;
            aux_r <= 1'b0;
            hold_r <= 1'b0;
            ready_n_r <= 1'b1;
            start_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            isr_r <= isr_nxt;
            osr_r <= osr_nxt;
            rw_r <= rw_nxt;
            sel_r <= sel_nxt;
            mode_r <= mode_nxt;
            ctrl_r <= ctrl_nxt;
            cal_r <= cal_nxt;
            main_d_r <= main_d_nxt;
            aux_d_r <= aux_d_nxt;
            main_r <= main_nxt;
            aux_r <= aux_nxt;
            hold_r <= hold_nxt;
            ready_n_r <= ready_n_nxt;
            start_r <= start_nxt;
        end
    end

    assign dout = osr_r[15];
    assign ready_n = ready_n_r;
    assign mode_start = start_r;
    assign mode_word = mode_r;
    assign ctrl_word = ctrl_r;
    assign cal_word = cal_r;

    // ------------------------------------------------------------
    // result fifo
    // ------------------------------------------------------------
    crf_fifo #(
        .W(crf_pkg::FIFO_W),
        .DEPTH(crf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(rst_all),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data({result_is_aux, result_data}),
        .out_valid(fifo_valid),
        .out_ready(drain_pop),
        .out_data(fifo_out)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_load_low;
        @(posedge clk) disable iff (rst_all)
        (drain_pop && !fifo_aux && main_enable) |=> main_r && !ready_n;
    endproperty
    a_load_low: assert property (p_load_low) else $error("ready high after main load");

    property p_read_high;
        @(posedge clk) disable iff (rst_all)
        (rd_done && sel_r == crf_pkg::SEL_MAIN && !hold_r && !drain_pop && !cal_done)
            |=> !main_r;
    endproperty
    a_read_high: assert property (p_read_high) else $error("main bit kept after read");

    property p_pre_update;
        @(posedge clk) disable iff (rst_all)
        (drain_clear && !fifo_aux && !cal_done) |=> !main_r ##1 (main_r || !main_enable);
    endproperty
    a_pre_update: assert property (p_pre_update) else $error("no high before update");

    property p_cal_low;
        @(posedge clk) disable iff (rst_all)
        (cal_done && main_enable) |=> !ready_n && hold_r;
    endproperty
    a_cal_low: assert property (p_cal_low) else $error("ready high after calibration");

    property p_nor;
        @(posedge clk) disable iff (srst)
        ready_n == !(main_r || aux_r);
    endproperty
    a_nor: assert property (p_nor) else $error("ready not nor of bits");

    property p_disabled;
        @(posedge clk) disable iff (rst_all)
        !aux_enable |=> !aux_r;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled aux bit set");

    property p_hold;
        @(posedge clk) disable iff (rst_all)
        (hold_r && main_enable && !start_nxt) |=> main_r && !ready_n;
    endproperty
    a_hold: assert property (p_hold) else $error("ready rose before mode write");

    property p_out_load;
        @(posedge clk) disable iff (rst_all)
        (cmd_done && isr_nxt[crf_pkg::COMM_SEL_LSB +: 4] == crf_pkg::SEL_CTRL)
            |=> osr_r == $past(ctrl_r);
    endproperty
    a_out_load: assert property (p_out_load) else $error("shift reg not loaded");

    property p_write;
        @(posedge clk) disable iff (rst_all)
        (wr_done && sel_r == crf_pkg::SEL_CTRL) |=> ctrl_r == $past(isr_nxt);
    endproperty
    a_write: assert property (p_write) else $error("control write lost");

    property p_reset;
        @(posedge clk) disable iff (srst)
        !rstn_f_r |=> ready_n && st_r == crf_pkg::ST_IDLE && cal_r == crf_pkg::CAL_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("reset pin ignored");

    c_main_load: cover property (@(posedge clk) drain_pop && !fifo_aux);
    c_full_read: cover property (@(posedge clk) rd_done && sel_r == crf_pkg::SEL_MAIN);
    c_cal_mode: cover property (@(posedge clk) hold_r ##[1:200] start_r);
endmodule

`default_nettype wire

// ---- crf_host.sv ----
// serial host model driving the register port of the ready flag block
`timescale 1ns/1ns
`default_nettype none

module crf_host #(
    parameter int HALF = 10
) (
    input wire logic clk,
    input wire logic dout,
    output logic sclk_pin,
    output logic cs_pin_n,
    output logic din_pin
);
    initial begin
        sclk_pin = 1'b0;
        cs_pin_n = 1'b1;
        din_pin = 1'b1;
    end

    // one frame: command byte then one 16-bit word, msb first
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sr;
        sr = {cmd, wd};
        rd = 16'h0000;
        @(negedge clk);
        cs_pin_n = 1'b0;
        for (int b = 0; b < 24; b++) begin
            din_pin = sr[23 - b];
            repeat (HALF) @(negedge clk);
            sclk_pin = 1'b1;
            repeat (HALF) @(negedge clk);
            if (b >= 7 && b <= 22) rd[22 - b] = dout;
            sclk_pin = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        cs_pin_n = 1'b1;
        // released line shows the inverse of its last level
        din_pin = ~din_pin;
        // keep deselect long enough for the pin filter to see it
        repeat (HALF) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ---- crf_ready_bench.sv ----
// self-checking bench for the conversion ready flag block
`timescale 1ns/1ns
`default_nettype none

module crf_ready_bench;
    logic clk;
    logic srst;
    logic reset_pin_n;
    logic sclk_pin;
    logic cs_pin_n;
    logic din_pin;
    logic dout;
    logic ready_n;
    logic main_enable;
    logic aux_enable;
    logic result_valid;
    logic result_is_aux;
    logic [15:0] result_data;
    logic result_ready;
    logic cal_done;
    logic mode_start;
    logic [15:0] mode_word;
    logic [15:0] ctrl_word;
    logic [15:0] cal_word;
    int error_cnt = 0;
    int checks = 0;
    int starts = 0;
    int seed = 84168;
    int hi;
    logic refused;
    logic [15:0] taken_q [$];
    logic [15:0] v;
    logic [15:0] a;
    logic [15:0] m_reg [0:2];
    logic [3:0] sels [0:2];

    crf_ready i_dut (.clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .sclk_pin(sclk_pin),
        .cs_pin_n(cs_pin_n), .din_pin(din_pin), .dout(dout), .ready_n(ready_n),
        .main_enable(main_enable), .aux_enable(aux_enable), .result_valid(result_valid),
        .result_is_aux(result_is_aux), .result_data(result_data), .result_ready(result_ready),
        .cal_done(cal_done), .mode_start(mode_start), .mode_word(mode_word),
        .ctrl_word(ctrl_word), .cal_word(cal_word));

    crf_host i_host (.clk(clk), .dout(dout), .sclk_pin(sclk_pin), .cs_pin_n(cs_pin_n),
        .din_pin(din_pin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mode_start === 1'b1) starts <= starts + 1;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd(input logic [3:0] sel, output logic [15:0] d);
        i_host.xfer({4'h4, sel}, 16'h0000, d);
    endtask

    task automatic wr(input logic [3:0] sel, input logic [15:0] d);
        logic [15:0] x;
        i_host.xfer({4'h0, sel}, d, x);
    endtask

    // n results, first one d0, the rest random; queues each taken word, notes any stall
    task automatic push(input logic aux, input int n, input logic [15:0] d0);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            result_valid = 1'b1;
            result_is_aux = aux;
            result_data = (i == 0) ? d0 : 16'($random(seed));
            // offer stands until the fifo takes it
            while (result_ready !== 1'b1) begin
                refused = 1'b1;
                @(negedge clk);
            end
            taken_q.push_back(result_data);
        end
        @(negedge clk);
        result_valid = 1'b0;
    endtask

    task automatic wait_rdy(input logic exp);
        for (int i = 0; i < 40 && ready_n !== exp; i++) @(negedge clk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #600000;
        error_cnt++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        srst = 1'b1;
        reset_pin_n = 1'b1;
        main_enable = 1'b1;
        aux_enable = 1'b1;
        result_valid = 1'b0;
        result_is_aux = 1'b0;
        result_data = 16'h0000;
        cal_done = 1'b0;
        refused = 1'b0;
        sels = '{crf_pkg::SEL_MODE, crf_pkg::SEL_CTRL, crf_pkg::SEL_CAL};
        repeat (3) @(negedge clk);
        srst = 1'b0;
        chk("ready_n", 16'(ready_n), 16'h0001);
        chk("cal_word", cal_word, crf_pkg::CAL_RST);
        chk("result_ready", 16'(result_ready), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            m_reg[i] = 16'($random(seed));
            wr(sels[i], m_reg[i]);
            rd(sels[i], v);
            chk("readback", v, m_reg[i]);
        end
        chk("mode_word", mode_word, m_reg[0]);
        chk("ctrl_word", ctrl_word, m_reg[1]);
        chk("cal_word", cal_word, m_reg[2]);
        wr(crf_pkg::SEL_STATUS, 16'hFFFF);
        rd(crf_pkg::SEL_STATUS, v);
        chk("status", v, 16'h0000);
        $display("test registers done");
        push(1'b1, 1, 16'hA5C3);
        wait_rdy(1'b0);
        chk("ready_n", 16'(ready_n), 16'h0000);
        push(1'b0, 1, 16'h3C5A);
        repeat (5) @(negedge clk);
        rd(crf_pkg::SEL_STATUS, v);
        chk("status", v, 16'h0003);
        rd(crf_pkg::SEL_AUX, v);
        chk("aux", v, 16'hA5C3);
        chk("ready_n", 16'(ready_n), 16'h0000);
        rd(crf_pkg::SEL_MAIN, v);
        chk("main", v, 16'h3C5A);
        chk("ready_n", 16'(ready_n), 16'h0001);
        $display("test read done");
        push(1'b0, 1, 16'h1234);
        wait_rdy(1'b0);
        hi = 0;
        push(1'b0, 1, 16'hFEDC);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            if (ready_n === 1'b1) hi = 1;
        end
        chk("pre_update_high", 16'(hi), 16'h0001);
        chk("ready_n", 16'(ready_n), 16'h0000);
        rd(crf_pkg::SEL_MAIN, v);
        chk("main", v, 16'hFEDC);
        $display("test unread done");
        main_enable = 1'b0;
        push(1'b0, 1, 16'h0F0F);
        repeat (10) @(negedge clk);
        chk("ready_n", 16'(ready_n), 16'h0001);
        push(1'b1, 1, 16'h7E81);
        wait_rdy(1'b0);
        rd(crf_pkg::SEL_STATUS, v);
        chk("status", v, 16'h0002);
        rd(crf_pkg::SEL_AUX, v);
        chk("ready_n", 16'(ready_n), 16'h0001);
        rd(crf_pkg::SEL_MAIN, v);
        chk("main", v, 16'h0F0F);
        main_enable = 1'b1;
        $display("test disable done");
        @(negedge clk);
        cal_done = 1'b1;
        @(negedge clk);
        cal_done = 1'b0;
        wait_rdy(1'b0);
        chk("ready_n", 16'(ready_n), 16'h0000);
        rd(crf_pkg::SEL_STATUS, v);
        chk("status", v, 16'h0005);
        rd(crf_pkg::SEL_MAIN, v);
        chk("ready_n", 16'(ready_n), 16'h0000);
        a = 16'($random(seed));
        wr(crf_pkg::SEL_MODE, a);
        repeat (2) @(negedge clk);
        chk("ready_n", 16'(ready_n), 16'h0001);
        chk("mode_starts", 16'(starts), 16'h0002);
        $display("test calibration done");
        push(1'b0, 60, 16'h0001);
        chk("refused", 16'(refused), 16'h0001);
        repeat (200) @(negedge clk);
        chk("result_ready", 16'(result_ready), 16'h0001);
        chk("ready_n", 16'(ready_n), 16'h0000);
        rd(crf_pkg::SEL_MAIN, v);
        chk("main", v, taken_q[$]);
        $display("test fifo done");
        push(1'b0, 1, 16'h4321);
        wait_rdy(1'b0);
        reset_pin_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_pin_n = 1'b1;
        repeat (10) @(negedge clk);
        chk("ready_n", 16'(ready_n), 16'h0001);
        chk("ctrl_word", ctrl_word, crf_pkg::CTRL_RST);
        chk("mode_word", mode_word, crf_pkg::MODE_RST);
        chk("cal_word", cal_word, crf_pkg::CAL_RST);
        rd(crf_pkg::SEL_CTRL, v);
        chk("ctrl", v, crf_pkg::CTRL_RST);
        $display("test reset pin done");
        final_report();
    end
endmodule
`default_nettype wire
